// ==== hw/ipfm_top.sv ====
// Interrupt pin function multiplexer with GPIO and writable vendor id, AHB-Lite register slave
`timescale 1ns/1ps
module ipfm_top (
  // Clock, reset, enable
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  input wire logic CE_IN,
  // AHB-Lite slave
  input wire logic HSEL_IN,
  input wire logic [ipfm_pkg::ADDR_W-1:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // Internal function sources
  input wire logic [ipfm_pkg::PIN_COUNT-1:0] IRQ_REQ_IN,
  input wire logic SPEAKER_OUTPUT_IN,
  input wire logic LOW_POWER_STATE_INDICATOR_IN,
  input wire logic CARD_ACTIVITY_LED_N_IN,
  input wire logic ZOOMED_VIDEO_ENABLE_N_IN,
  input wire logic SERIAL_INTERRUPT_LINE_N_IN,
  input wire logic SERIAL_INTERRUPT_OE_IN,
  // Pins, each split into input, output and output enable
  input wire logic [ipfm_pkg::PIN_COUNT-1:0] PIN_IN,
  output logic [ipfm_pkg::PIN_COUNT-1:0] PIN_OUT,
  output logic [ipfm_pkg::PIN_COUNT-1:0] PIN_OE_OUT,
  // Serial interrupt line as seen on its pin
  output logic SERIAL_INTERRUPT_LINE_N_OUT
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [31:0] pin_select;
  logic [7:0] gpio_reg;
  logic [15:0] vendor_id;
  logic [1:0] mode_ctrl;
  logic [ipfm_pkg::GPIO_COUNT-1:0] gpio_in_q;
  ipfm_pkg::ipfm_bus_req_t dphase;
  logic dphase_valid;

  default clocking @(posedge MCLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire take_addr = HSEL_IN && HREADY_IN && HTRANS_IN[1] && CE_IN;
  wire [3:0] next_strb = (HSIZE_IN == ipfm_pkg::HSIZE_BYTE) ? (4'h1 << HADDR_IN[1:0]) :
                         (HSIZE_IN == ipfm_pkg::HSIZE_HALF) ? (HADDR_IN[1] ? 4'hC : 4'h3) : 4'hF;
  wire wr_commit = dphase_valid && dphase.write && CE_IN;
  wire [ipfm_pkg::ADDR_W-1:0] word_addr = {dphase.addr[ipfm_pkg::ADDR_W-1:2], 2'h0};
  wire hit_select = word_addr == ipfm_pkg::ADDR_PIN_SELECT;
  wire hit_gpio = (word_addr == ipfm_pkg::ADDR_GPIO_CFG) || (word_addr == ipfm_pkg::ADDR_GPIO_CARD);
  wire hit_vendor_wr = word_addr == ipfm_pkg::ADDR_VENDOR_WR;
  wire hit_vendor_ro = word_addr == ipfm_pkg::ADDR_VENDOR_RO;
  wire hit_mode = word_addr == ipfm_pkg::ADDR_MODE_CTRL;
  wire [31:0] wmask = {{8{dphase.strb[3]}}, {8{dphase.strb[2]}}, {8{dphase.strb[1]}}, {8{dphase.strb[0]}}};

  // ----------------------------------------
  // Mode and GPIO qualification
  // ----------------------------------------
  wire serial_mode = mode_ctrl[ipfm_pkg::MODE_SERIAL_BIT];
  wire led_drive_option = mode_ctrl[ipfm_pkg::MODE_LED_OPT_BIT];
  wire gpio_enable = pin_select[ipfm_pkg::GPIO_ENABLE_BIT];
  wire gpio_ok = gpio_enable && serial_mode;
  wire [ipfm_pkg::GPIO_COUNT-1:0] gpio_dir = gpio_reg[ipfm_pkg::GPIO_DIR_LSB +: ipfm_pkg::GPIO_COUNT];
  wire [ipfm_pkg::GPIO_COUNT-1:0] gpio_data = gpio_reg[ipfm_pkg::GPIO_COUNT-1:0];
  // Input lines read back the sampled pin, output lines the stored bit
  wire [ipfm_pkg::GPIO_COUNT-1:0] gpio_view = (gpio_dir & gpio_data) | (~gpio_dir & gpio_in_q);

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire [31:0] rd_gpio = {24'h000000, gpio_dir, gpio_view};
  wire [31:0] rd_vendor = {16'h0000, vendor_id};
  wire [31:0] rd_mode = {30'h00000000, mode_ctrl};
  wire [31:0] rd_word = hit_select ? pin_select :
                        hit_gpio ? rd_gpio :
                        (hit_vendor_wr || hit_vendor_ro) ? rd_vendor :
                        hit_mode ? rd_mode : 32'h00000000;

  // Zero wait states; a low enable stalls the bus so frozen state stays coherent
  assign HREADYOUT_OUT = CE_IN;
  assign HRESP_OUT = 1'b0;
  assign HRDATA_OUT = (dphase_valid && !dphase.write) ? rd_word : 32'h00000000;

  // ----------------------------------------
  // Write merges
  // ----------------------------------------
  wire [31:0] next_select = (pin_select & ~wmask) | (HWDATA_IN & wmask);
  wire [7:0] next_gpio = (gpio_reg & ~wmask[7:0]) | (HWDATA_IN[7:0] & wmask[7:0]);
  wire [15:0] next_vendor = (vendor_id & ~wmask[15:0]) | (HWDATA_IN[15:0] & wmask[15:0]);
  wire [1:0] next_mode = (mode_ctrl & ~wmask[1:0]) | (HWDATA_IN[1:0] & wmask[1:0]);

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      dphase_valid <= 1'b0;
      dphase <= '0;
    end else if (CE_IN) begin
      dphase_valid <= take_addr;
      if (take_addr) begin
        dphase <= '{write: HWRITE_IN, addr: HADDR_IN, strb: next_strb};
      end
    end
  end

  // Global reset is the only reset here, so it alone clears the vendor id
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pin_select <= ipfm_pkg::PIN_SELECT_RESET;
      gpio_reg <= ipfm_pkg::GPIO_RESET;
      vendor_id <= ipfm_pkg::VENDOR_RESET;
      mode_ctrl <= ipfm_pkg::MODE_RESET;
    end else if (wr_commit) begin
      if (hit_select) pin_select <= next_select;
      if (hit_gpio) gpio_reg <= next_gpio;
      if (hit_vendor_wr) vendor_id <= next_vendor;
      if (hit_mode) mode_ctrl <= next_mode;
    end
  end

  // Inputs are ignored while GPIO is not enabled
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      gpio_in_q <= '0;
    end else if (CE_IN) begin
      gpio_in_q <= gpio_ok ? PIN_IN[ipfm_pkg::GPIO_COUNT-1:0] : '0;
    end
  end

  // ----------------------------------------
  // Pin function selection
  // ----------------------------------------
  wire irq12_prog = led_drive_option ? CARD_ACTIVITY_LED_N_IN : IRQ_REQ_IN[ipfm_pkg::PIN_IRQ12];

  function automatic ipfm_pkg::ipfm_drive_t drive_of(input ipfm_pkg::ipfm_func_t f, input logic own,
                                                      input logic gp_ok, input logic gp_dir, input logic gp_dat);
    ipfm_pkg::ipfm_drive_t d;
    d = '{val: 1'b0, oe: 1'b1};
    unique case (f)
      ipfm_pkg::F_OWN: d.val = own;
      ipfm_pkg::F_SPK: d.val = SPEAKER_OUTPUT_IN;
      ipfm_pkg::F_D3: d.val = LOW_POWER_STATE_INDICATOR_IN;
      ipfm_pkg::F_LED: d.val = CARD_ACTIVITY_LED_N_IN;
      ipfm_pkg::F_ZV: d.val = ZOOMED_VIDEO_ENABLE_N_IN;
      ipfm_pkg::F_HIZ: d.oe = 1'b0;
      ipfm_pkg::F_IRQ3: d.val = IRQ_REQ_IN[ipfm_pkg::PIN_IRQ3];
      ipfm_pkg::F_IRQ4: d.val = IRQ_REQ_IN[ipfm_pkg::PIN_IRQ4];
      ipfm_pkg::F_IRQ5: d.val = IRQ_REQ_IN[ipfm_pkg::PIN_IRQ5];
      ipfm_pkg::F_IRQ12P: d.val = irq12_prog;
      ipfm_pkg::F_IRQ14: d.val = IRQ_REQ_IN[ipfm_pkg::PIN_IRQ14];
      ipfm_pkg::F_IRQ15: d.val = IRQ_REQ_IN[ipfm_pkg::PIN_IRQ15];
      ipfm_pkg::F_GPIO: begin
        d.val = gp_dat;
        d.oe = gp_ok && gp_dir;
      end
      ipfm_pkg::F_SERIRQ: begin
        d.val = SERIAL_INTERRUPT_LINE_N_IN;
        d.oe = SERIAL_INTERRUPT_OE_IN;
      end
      default: d.oe = 1'b0;
    endcase
    return d;
  endfunction

  ipfm_pkg::ipfm_func_t pin_func [ipfm_pkg::PIN_COUNT];
  ipfm_pkg::ipfm_drive_t next_drive [ipfm_pkg::PIN_COUNT];
  logic [ipfm_pkg::GPIO_COUNT-1:0] gpio_pick;

  genvar p;
  generate
    for (p = 0; p < ipfm_pkg::PIN_COUNT; p++) begin : g_pin
      localparam int LSB = p * ipfm_pkg::SEL_W;
      wire [ipfm_pkg::SEL_W-1:0] sel = pin_select[LSB +: ipfm_pkg::SEL_W];
      wire sel_zero = sel == '0;
      // Serial mode swaps code 0 meaning; the serial line pin ignores its select entirely
      wire serial_fixed = serial_mode && (p == ipfm_pkg::PIN_IRQ9);
      assign pin_func[p] = serial_fixed ? ipfm_pkg::F_SERIRQ :
                           (serial_mode && sel_zero) ? ipfm_pkg::SERIAL_MAP[p] :
                           ipfm_pkg::FUNC_MAP[p][sel];
      if (p < ipfm_pkg::GPIO_COUNT) begin : g_gpio
        assign next_drive[p] = drive_of(pin_func[p], IRQ_REQ_IN[p], gpio_ok, gpio_dir[p], gpio_data[p]);
        assign gpio_pick[p] = pin_func[p] == ipfm_pkg::F_GPIO;
      end else begin : g_plain
        assign next_drive[p] = drive_of(pin_func[p], IRQ_REQ_IN[p], 1'b0, 1'b0, 1'b0);
      end
      // Registered so a select change switches the pin cleanly on one edge
      always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
          PIN_OUT[p] <= 1'b0;
          PIN_OE_OUT[p] <= 1'b0;
        end else if (CE_IN) begin
          PIN_OUT[p] <= next_drive[p].val;
          PIN_OE_OUT[p] <= next_drive[p].oe;
        end
      end
    end
  endgenerate

  assign SERIAL_INTERRUPT_LINE_N_OUT = PIN_IN[ipfm_pkg::PIN_IRQ9];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_hiz_code: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (CE_IN && !serial_mode && pin_select[29:27] == 3'h5) |=> !PIN_OE_OUT[ipfm_pkg::PIN_IRQ15])
    else $error("IRQ15 pin driven while hi-z selected");

  chk_irq14_swap: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (CE_IN && pin_select[26:24] == 3'h4) |=> (PIN_OUT[ipfm_pkg::PIN_IRQ14] == $past(IRQ_REQ_IN[1])
      && PIN_OE_OUT[ipfm_pkg::PIN_IRQ14]))
    else $error("IRQ14 pin does not carry IRQ4");

  chk_irq12_option: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (CE_IN && pin_select[23:21] == 3'h0 && led_drive_option)
      |=> PIN_OUT[ipfm_pkg::PIN_IRQ12] == $past(CARD_ACTIVITY_LED_N_IN))
    else $error("IRQ12 pin ignores LED drive option");

  chk_serial_fixed: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (CE_IN && serial_mode) |=> (PIN_OE_OUT[ipfm_pkg::PIN_IRQ9] == $past(SERIAL_INTERRUPT_OE_IN)
      && PIN_OUT[ipfm_pkg::PIN_IRQ9] == $past(SERIAL_INTERRUPT_LINE_N_IN)))
    else $error("Serial interrupt pin not fixed in serial mode");

  chk_gpio_off: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (CE_IN && !gpio_ok) |=> ((PIN_OE_OUT[3:0] & $past(gpio_pick)) == 4'h0))
    else $error("GPIO pin driven while GPIO disabled");

  chk_gpio_drive: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (CE_IN && gpio_ok && gpio_pick[0] && gpio_dir[0])
      |=> (PIN_OE_OUT[0] && PIN_OUT[0] == $past(gpio_data[0])))
    else $error("GPIO0 output does not follow data bit");

  chk_gpio_shared: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (wr_commit && word_addr == ipfm_pkg::ADDR_GPIO_CARD && dphase.strb[0])
      |=> gpio_dir == $past(HWDATA_IN[7:4]))
    else $error("Card-space GPIO write not seen in shared storage");

  chk_vendor_mirror: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (dphase_valid && !dphase.write && hit_vendor_ro) |-> HRDATA_OUT == {16'h0000, vendor_id})
    else $error("Vendor id read location does not mirror writable value");

  chk_freeze_hold: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    !CE_IN [*2] |-> ($stable(pin_select) && $stable(PIN_OE_OUT)))
    else $error("State changed while clock enable low");

  chk_irq15_d3: assert property (
    (CE_IN && pin_select[29:27] == 3'h2)
    |=> PIN_OUT[9] == $past(LOW_POWER_STATE_INDICATOR_IN))
    else $error("IRQ15 pin not D3");

  chk_irq15_irq5: assert property (
    (CE_IN && pin_select[29:27] == 3'h7)
    |=> PIN_OUT[9] == $past(IRQ_REQ_IN[2]))
    else $error("IRQ15 pin not IRQ5");

  chk_irq15_serial: assert property (
    (CE_IN && serial_mode && pin_select[29:27] == 3'h0)
    |=> PIN_OUT[9] == $past(ZOOMED_VIDEO_ENABLE_N_IN))
    else $error("IRQ15 pin not video");

  chk_irq14_led: assert property (
    (CE_IN && pin_select[26:24] == 3'h2)
    |=> PIN_OUT[8] == $past(CARD_ACTIVITY_LED_N_IN))
    else $error("IRQ14 pin not LED");

  chk_irq14_d3: assert property (
    (CE_IN && pin_select[26:24] == 3'h7)
    |=> PIN_OUT[8] == $past(LOW_POWER_STATE_INDICATOR_IN))
    else $error("IRQ14 pin not D3");

  chk_irq12_irq3: assert property (
    (CE_IN && pin_select[23:21] == 3'h4)
    |=> PIN_OUT[7] == $past(IRQ_REQ_IN[0]))
    else $error("IRQ12 pin not IRQ3");

  chk_irq12_spk: assert property (
    (CE_IN && pin_select[23:21] == 3'h5)
    |=> PIN_OUT[7] == $past(SPEAKER_OUTPUT_IN))
    else $error("IRQ12 pin not speaker");

  chk_irq12_d3: assert property (
    (CE_IN && pin_select[23:21] == 3'h7)
    |=> PIN_OUT[7] == $past(LOW_POWER_STATE_INDICATOR_IN))
    else $error("IRQ12 pin not D3");

  chk_irq11_d3: assert property (
    (CE_IN && pin_select[20:18] == 3'h2)
    |=> PIN_OUT[6] == $past(LOW_POWER_STATE_INDICATOR_IN))
    else $error("IRQ11 pin not D3");

  chk_irq11_prog: assert property (
    (CE_IN && !led_drive_option && pin_select[20:18] == 3'h7)
    |=> PIN_OUT[6] == $past(IRQ_REQ_IN[7]))
    else $error("IRQ11 pin not IRQ12");

  chk_irq10_irq15: assert property (
    (CE_IN && pin_select[17:15] == 3'h5)
    |=> PIN_OUT[5] == $past(IRQ_REQ_IN[9]))
    else $error("IRQ10 pin not IRQ15");

  chk_irq10_hiz: assert property (
    (CE_IN && pin_select[17:15] == 3'h7)
    |=> !PIN_OE_OUT[5])
    else $error("IRQ10 pin driven in hi-z");

  chk_irq10_serial: assert property (
    (CE_IN && serial_mode && pin_select[17:15] == 3'h0)
    |=> PIN_OUT[5] == $past(CARD_ACTIVITY_LED_N_IN))
    else $error("IRQ10 pin not LED");

  chk_irq9_led: assert property (
    (CE_IN && !serial_mode && pin_select[14:12] == 3'h4)
    |=> PIN_OUT[4] == $past(CARD_ACTIVITY_LED_N_IN))
    else $error("IRQ9 pin not LED");

  chk_irq9_hiz: assert property (
    (CE_IN && !serial_mode && pin_select[14:12] == 3'h7)
    |=> !PIN_OE_OUT[4])
    else $error("IRQ9 pin driven in hi-z");

  chk_irq7_irq14: assert property (
    (CE_IN && pin_select[11:9] == 3'h2)
    |=> PIN_OUT[3] == $past(IRQ_REQ_IN[8]))
    else $error("IRQ7 pin not IRQ14");

  chk_irq7_hiz: assert property (
    (CE_IN && pin_select[11:9] == 3'h5)
    |=> !PIN_OE_OUT[3])
    else $error("IRQ7 pin driven in hi-z");

  chk_irq5_irq12: assert property (
    (CE_IN && !led_drive_option && pin_select[8:6] == 3'h2)
    |=> PIN_OUT[2] == $past(IRQ_REQ_IN[7]))
    else $error("IRQ5 pin not IRQ12");

  chk_irq4_d3: assert property (
    (CE_IN && pin_select[5:3] == 3'h2)
    |=> PIN_OUT[1] == $past(LOW_POWER_STATE_INDICATOR_IN))
    else $error("IRQ4 pin not D3");

  chk_irq3_video: assert property (
    (CE_IN && pin_select[2:0] == 3'h4)
    |=> PIN_OUT[0] == $past(ZOOMED_VIDEO_ENABLE_N_IN))
    else $error("IRQ3 pin not video");

  chk_irq3_spk: assert property (
    (CE_IN && (pin_select[2:0] == 3'h1 || pin_select[2:0] == 3'h6))
    |=> PIN_OUT[0] == $past(SPEAKER_OUTPUT_IN))
    else $error("IRQ3 pin not speaker");

  chk_reset_clear: assert property (
    $rose(RESET_N_IN)
    |-> (pin_select == '0 && gpio_reg == '0 && vendor_id == '0))
    else $error("Register not cleared by reset");

  chk_gpio_gated: assert property (
    (CE_IN && !serial_mode)
    |=> gpio_in_q == '0)
    else $error("GPIO input taken outside serial mode");

  chk_gpio_input: assert property (
    (CE_IN && gpio_ok && gpio_pick[1] && !gpio_dir[1])
    |=> !PIN_OE_OUT[1])
    else $error("GPIO1 input line driven");

  chk_vendor_hold: assert property (
    !(wr_commit && hit_vendor_wr)
    |=> $stable(vendor_id))
    else $error("Vendor id changed without write");

endmodule

// ==== include/ipfm_pkg.sv ====
// Constants, types and pin function tables for the interrupt pin function multiplexer
//
// Overview of operation
// - IRQ15 pin: 0 own irq or video enable, 1/6 speaker, 2 D3, 3 LED, 4 video, 5 hi-z, 7 IRQ5.
// - IRQ14 pin: 0 own irq, 1/6 speaker, 2 LED, 3 video, 4 IRQ4, 5 hi-z, 7 D3.
// - IRQ12 pin: 0 programmable IRQ12, 1/5/6 speaker, 2 LED, 3 video, 4 IRQ3, 7 D3.
// - IRQ11 pin: 0 own irq, 1/6 speaker, 2 D3, 3 LED, 4 video, 5 hi-z, 7 programmable IRQ12.
// - IRQ10 pin: 0 own irq or LED, 1/6 speaker, 2 LED, 3 video, 4 IRQ12, 5 IRQ15, 7 hi-z.
// - IRQ9 pin: select table as listed; fixed serial interrupt line in serial mode.
// - IRQ7 pin: 0 own irq or GPIO3, 1/6 speaker, 2 IRQ14, 3 LED, 4 video, 5 hi-z, 7 GPIO3.
// - IRQ5 pin: 0 own irq or GPIO2, 1/6 speaker, 2 IRQ12, 3 LED, 4 video, 5 hi-z, 7 GPIO2.
// - IRQ4 pin: 0 own irq or GPIO1, 1/6 speaker, 2 D3, 3 LED, 4 video, 5 hi-z, 7 GPIO1.
// - IRQ3 pin: 0 own irq or GPIO0, 1/6 speaker, 2 IRQ12, 3 LED, 4 video, 5 hi-z, 7 GPIO0.
// - All pin select fields clear to zero on reset.
// - GPIO pins only when serial interrupt mode and GPIO enable are both set.
// - GPIO lines start as inputs; data bits read back sampled pin states.
// - Bits 7..4 are GPIO directions, one means output, reset to zero.
// - An output GPIO line drives its last written data bit.
// - Both GPIO register locations share one storage.
// - Writable subsystem vendor id is read back at the read-only vendor id location.
// - Only global reset clears the writable subsystem vendor id.
// - GPIO enable low puts GPIO outputs in hi-z and ignores GPIO inputs.
package ipfm_pkg;

  localparam int ADDR_W = 14;
  localparam int PIN_COUNT = 10;
  localparam int SEL_W = 3;
  localparam int GPIO_COUNT = 4;

  // Printed offsets are register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_VENDOR_RO = 14'h0040;
  localparam logic [ADDR_W-1:0] IDX_PIN_SELECT = 14'h00A4;
  localparam logic [ADDR_W-1:0] IDX_GPIO_CFG = 14'h00AA;
  localparam logic [ADDR_W-1:0] IDX_MODE_CTRL = 14'h00B0;
  localparam logic [ADDR_W-1:0] IDX_VENDOR_WR = 14'h00C0;
  localparam logic [ADDR_W-1:0] IDX_GPIO_CARD = 14'h083A;
  localparam logic [ADDR_W-1:0] ADDR_VENDOR_RO = IDX_VENDOR_RO << 2;
  localparam logic [ADDR_W-1:0] ADDR_PIN_SELECT = IDX_PIN_SELECT << 2;
  localparam logic [ADDR_W-1:0] ADDR_GPIO_CFG = IDX_GPIO_CFG << 2;
  localparam logic [ADDR_W-1:0] ADDR_MODE_CTRL = IDX_MODE_CTRL << 2;
  localparam logic [ADDR_W-1:0] ADDR_VENDOR_WR = IDX_VENDOR_WR << 2;
  localparam logic [ADDR_W-1:0] ADDR_GPIO_CARD = IDX_GPIO_CARD << 2;

  // Field layout and reset values
  localparam int GPIO_ENABLE_BIT = 31;
  localparam int GPIO_DIR_LSB = 4;
  localparam int MODE_SERIAL_BIT = 0;
  localparam int MODE_LED_OPT_BIT = 1;
  localparam logic [31:0] PIN_SELECT_RESET = 32'h0000_0000;
  localparam logic [7:0] GPIO_RESET = 8'h00;
  localparam logic [15:0] VENDOR_RESET = 16'h0000;
  localparam logic [1:0] MODE_RESET = 2'h0;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE = 3'h0;
  localparam logic [2:0] HSIZE_HALF = 3'h1;

  typedef enum logic [3:0] {
    F_OWN = 4'h0, F_SPK = 4'h1, F_D3 = 4'h2, F_LED = 4'h3,
    F_ZV = 4'h4, F_HIZ = 4'h5, F_IRQ3 = 4'h6, F_IRQ4 = 4'h7,
    F_IRQ5 = 4'h8, F_IRQ12P = 4'h9, F_IRQ14 = 4'hA, F_IRQ15 = 4'hB,
    F_GPIO = 4'hC, F_SERIRQ = 4'hD
  } ipfm_func_t;

  // Pin order: IRQ3, IRQ4, IRQ5, IRQ7, IRQ9, IRQ10, IRQ11, IRQ12, IRQ14, IRQ15
  localparam int PIN_IRQ3 = 0;
  localparam int PIN_IRQ4 = 1;
  localparam int PIN_IRQ5 = 2;
  localparam int PIN_IRQ9 = 4;
  localparam int PIN_IRQ12 = 7;
  localparam int PIN_IRQ14 = 8;
  localparam int PIN_IRQ15 = 9;

  localparam ipfm_func_t FUNC_MAP [PIN_COUNT][8] = '{
    '{F_OWN, F_SPK, F_IRQ12P, F_LED, F_ZV, F_HIZ, F_SPK, F_GPIO},
    '{F_OWN, F_SPK, F_D3, F_LED, F_ZV, F_HIZ, F_SPK, F_GPIO},
    '{F_OWN, F_SPK, F_IRQ12P, F_LED, F_ZV, F_HIZ, F_SPK, F_GPIO},
    '{F_OWN, F_SPK, F_IRQ14, F_LED, F_ZV, F_HIZ, F_SPK, F_GPIO},
    '{F_OWN, F_SPK, F_IRQ12P, F_ZV, F_LED, F_IRQ15, F_SPK, F_HIZ},
    '{F_OWN, F_SPK, F_LED, F_ZV, F_IRQ12P, F_IRQ15, F_SPK, F_HIZ},
    '{F_OWN, F_SPK, F_D3, F_LED, F_ZV, F_HIZ, F_SPK, F_IRQ12P},
    '{F_IRQ12P, F_SPK, F_LED, F_ZV, F_IRQ3, F_SPK, F_SPK, F_D3},
    '{F_OWN, F_SPK, F_LED, F_ZV, F_IRQ4, F_HIZ, F_SPK, F_D3},
    '{F_OWN, F_SPK, F_D3, F_LED, F_ZV, F_HIZ, F_SPK, F_IRQ5}
  };

  // Code 0 meaning while serial interrupt mode is on
  localparam ipfm_func_t SERIAL_MAP [PIN_COUNT] = '{
    F_GPIO, F_GPIO, F_GPIO, F_GPIO, F_SERIRQ, F_LED, F_OWN, F_IRQ12P, F_OWN, F_ZV
  };

  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [3:0] strb;
  } ipfm_bus_req_t;

  typedef struct packed {
    logic val;
    logic oe;
  } ipfm_drive_t;

endpackage

// ==== verification/ipfm_board_model.sv ====
// Board-side model of the ten multiplexed interrupt pins
`timescale 1ns/1ps
module ipfm_board_model (
  // Clock
  input wire logic clk_in,
  // Pin drive from the device
  input wire logic [ipfm_pkg::PIN_COUNT-1:0] pin_out_in,
  input wire logic [ipfm_pkg::PIN_COUNT-1:0] pin_oe_in,
  // Board drivers
  input wire logic [ipfm_pkg::PIN_COUNT-1:0] ext_val_in,
  input wire logic [ipfm_pkg::PIN_COUNT-1:0] ext_en_in,
  // Resolved pin levels
  output logic [ipfm_pkg::PIN_COUNT-1:0] level_out
);
  logic [ipfm_pkg::PIN_COUNT-1:0] last = '0;
  // No serial ROM fitted, so the IRQ12 pin may take alternates
  // Floating pins toggle, so a stale level never passes for a driven one
  always_comb begin
    for (int i = 0; i < ipfm_pkg::PIN_COUNT; i++) begin
      level_out[i] = pin_oe_in[i] ? pin_out_in[i] : (ext_en_in[i] ? ext_val_in[i] : ~last[i]);
    end
  end
  always_ff @(posedge clk_in) begin
    last <= level_out;
  end
endmodule

// ==== verification/irq_pin_function_mux_tb_top.sv ====
// Self-checking bench for the interrupt pin function multiplexer
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
  $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module irq_pin_function_mux_tb_top;
  // ----------------
  // Signals
  // ----------------
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [13:0] haddr = 14'h0000;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic [9:0] irq = 10'h000;
  logic spk = 1'b0;
  logic d3 = 1'b0;
  logic led_n = 1'b1;
  logic zv_n = 1'b1;
  logic ser_n = 1'b1;
  logic ser_oe = 1'b0;
  logic ce = 1'b1;
  logic ser_line_n;
  logic [9:0] pin_in;
  logic [9:0] pin_out;
  logic [9:0] pin_oe;
  logic [9:0] ext_val = 10'h000;
  logic [9:0] ext_en = 10'h000;
  int miscompares = 0;
  int check_count = 0;
  // Source per pin and code: 0..9 own irq lines, 10 speaker, 11 D3, 12 LED, 13 video, 14 hi-z, 15 GPIO
  int tbl [10][8] = '{'{0, 10, 7, 12, 13, 14, 10, 15}, '{1, 10, 11, 12, 13, 14, 10, 15},
    '{2, 10, 7, 12, 13, 14, 10, 15}, '{3, 10, 8, 12, 13, 14, 10, 15}, '{4, 10, 7, 13, 12, 9, 10, 14},
    '{5, 10, 12, 13, 7, 9, 10, 14}, '{6, 10, 11, 12, 13, 14, 10, 7}, '{7, 10, 12, 13, 0, 10, 10, 11},
    '{8, 10, 12, 13, 1, 14, 10, 11}, '{9, 10, 11, 12, 13, 14, 10, 2}};
  int ser_map [10] = '{15, 15, 15, 15, 16, 12, 6, 7, 8, 13};

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  ipfm_top dut (.MCLK_IN(mclk), .RESET_N_IN(rst_n), .CE_IN(ce), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .IRQ_REQ_IN(irq),
    .SPEAKER_OUTPUT_IN(spk), .LOW_POWER_STATE_INDICATOR_IN(d3), .CARD_ACTIVITY_LED_N_IN(led_n),
    .ZOOMED_VIDEO_ENABLE_N_IN(zv_n), .SERIAL_INTERRUPT_LINE_N_IN(ser_n), .SERIAL_INTERRUPT_OE_IN(ser_oe),
    .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE_OUT(pin_oe), .SERIAL_INTERRUPT_LINE_N_OUT(ser_line_n));

  ipfm_board_model board (.clk_in(mclk), .pin_out_in(pin_out), .pin_oe_in(pin_oe), .ext_val_in(ext_val),
    .ext_en_in(ext_en), .level_out(pin_in));

  // ----------------
  // Bus and check tasks
  // ----------------
  task automatic ahb(input logic w, input logic [13:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= ipfm_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1) @(posedge mclk);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(1'b1, a, d, rd);
  endtask

  task automatic rdchk(input logic [13:0] a, input logic [31:0] e);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0000_0000, rd);
    `CHK(rd, e)
  endtask

  // Each select-table source carries a distinct 4-bit signature over the four patterns
  task automatic run_pins(input logic [31:0] sel, input logic [1:0] mode);
    logic [9:0] eo;
    logic [9:0] ev;
    int s;
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      for (int i = 0; i < 10; i++) begin
        irq[i] <= 1'((i + 1) >> k);
      end
      spk <= 1'(11 >> k);
      d3 <= 1'(12 >> k);
      led_n <= 1'(13 >> k);
      zv_n <= 1'(14 >> k);
      ser_n <= 1'(k);
      ser_oe <= 1'(k >> 1);
      @(posedge mclk);
      #1;
      for (int j = 0; j < 10; j++) begin
        s = tbl[j][sel[3*j+:3]];
        if (mode[0] && sel[3*j+:3] == 3'h0) s = ser_map[j];
        if (mode[0] && j == 4) s = 16;
        if (mode[1] && s == 7) s = 12;
        eo[j] = (s < 14) ? 1'b1 : ((s == 16) ? 1'(k >> 1) : 1'b0);
        ev[j] = (s < 14) ? 1'((s + 1) >> k) : ((s == 16) ? 1'(k) : 1'b0);
      end
      `CHK(pin_oe, eo)
      `CHK(pin_out & eo, ev & eo)
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------
  // Tests
  // ----------------
  initial begin
    logic [31:0] v;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(ipfm_pkg::ADDR_PIN_SELECT, 32'h0000_0000);
    rdchk(ipfm_pkg::ADDR_GPIO_CFG, 32'h0000_0000);
    rdchk(ipfm_pkg::ADDR_VENDOR_WR, 32'h0000_0000);
    run_pins(32'h0000_0000, 2'h0);
    wr(14'h0004, 32'hFFFF_FFFF);
    rdchk(14'h0004, 32'h0000_0000);
    $display("test reset_values done");
    for (int p = 0; p < 10; p++) begin
      for (int c = 0; c < 8; c++) begin
        v = 32'(c) << (3 * p);
        wr(ipfm_pkg::ADDR_PIN_SELECT, v);
        rdchk(ipfm_pkg::ADDR_PIN_SELECT, v);
        run_pins(v, 2'h0);
      end
    end
    $display("test select_sweep done");
    wr(ipfm_pkg::ADDR_MODE_CTRL, 32'h0000_0002);
    wr(ipfm_pkg::ADDR_PIN_SELECT, 32'h001C_0000);
    run_pins(32'h001C_0000, 2'h2);
    wr(ipfm_pkg::ADDR_MODE_CTRL, 32'h0000_0000);
    wr(ipfm_pkg::ADDR_PIN_SELECT, 32'h8000_0007);
    run_pins(32'h8000_0007, 2'h0);
    wr(ipfm_pkg::ADDR_MODE_CTRL, 32'h0000_0001);
    wr(ipfm_pkg::ADDR_PIN_SELECT, 32'h0000_1000);
    run_pins(32'h0000_1000, 2'h1);
    `CHK(ser_line_n, 1'b1)
    @(posedge mclk);
    ser_n <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK(ser_line_n, 1'b0)
    $display("test modes done");
    ext_en <= 10'h00F;
    ext_val <= 10'h00A;
    wr(ipfm_pkg::ADDR_PIN_SELECT, 32'h8000_0000);
    @(posedge mclk);
    #1;
    `CHK(pin_oe[3:0], 4'h0)
    rdchk(ipfm_pkg::ADDR_GPIO_CFG, 32'h0000_000A);
    wr(ipfm_pkg::ADDR_GPIO_CFG, 32'h0000_00F5);
    @(posedge mclk);
    #1;
    `CHK(pin_oe[3:0], 4'hF)
    `CHK(pin_out[3:0], 4'h5)
    rdchk(ipfm_pkg::ADDR_GPIO_CARD, 32'h0000_00F5);
    wr(ipfm_pkg::ADDR_GPIO_CARD, 32'h0000_003C);
    @(posedge mclk);
    #1;
    `CHK({pin_oe[3:0], pin_out[1:0]}, 6'h0C)
    rdchk(ipfm_pkg::ADDR_GPIO_CFG, 32'h0000_0038);
    wr(ipfm_pkg::ADDR_PIN_SELECT, 32'h0000_0000);
    @(posedge mclk);
    #1;
    `CHK(pin_oe[3:0], 4'h0)
    rdchk(ipfm_pkg::ADDR_GPIO_CFG, 32'h0000_0030);
    $display("test gpio done");
    wr(ipfm_pkg::ADDR_VENDOR_WR, 32'h0000_5A3C);
    rdchk(ipfm_pkg::ADDR_VENDOR_RO, 32'h0000_5A3C);
    rdchk(ipfm_pkg::ADDR_VENDOR_WR, 32'h0000_5A3C);
    wr(ipfm_pkg::ADDR_PIN_SELECT, 32'hFFFF_FFFF);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(ipfm_pkg::ADDR_PIN_SELECT, 32'h0000_0000);
    rdchk(ipfm_pkg::ADDR_GPIO_CFG, 32'h0000_0000);
    rdchk(ipfm_pkg::ADDR_VENDOR_RO, 32'h0000_0000);
    run_pins(32'h0000_0000, 2'h0);
    @(posedge mclk);
    ce <= 1'b0;
    irq <= 10'h07F;
    repeat (3) @(posedge mclk);
    #1;
    `CHK(pin_out, 10'h380)
    `CHK(hready, 1'b0)
    @(posedge mclk);
    ce <= 1'b1;
    @(posedge mclk);
    #1;
    `CHK(pin_out, 10'h07F)
    $display("test vendor_and_reset done");
    stop_test();
  end

  initial begin
    #100000;
    miscompares++;
    $display("watchdog expired");
    stop_test();
  end
endmodule
